// ### rtl/msx_exec.sv
// decode and execute of store, nibble swap, literal xor and direction load
`timescale 1ns/1ps
module msx_exec (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST_B,
  // instruction issue
  input wire msx_pkg::msx_issue_t ISSUE,
  // file register read data for the issued address, same cycle
  input wire logic [7:0] FILE_RDATA,
  // file register read address and write request
  output logic [6:0] FILE_RADDR,
  output msx_pkg::msx_fwrite_t FILE_WR,
  // core state
  output logic [7:0] ACC,
  output logic ZERO,
  output logic [23:0] DIR_REGS,
  // unrecognised word seen
  output logic UNHANDLED
);
  import msx_pkg::*;

  // swap nibbles; the checks below spell the bit moves out by hand so that
  // a slip in this helper cannot hide behind its own expectation
  function automatic logic [7:0] nib_swap(input logic [7:0] v);
    return {v[3:0], v[7:4]};
  endfunction

  logic [7:0] acc;
  logic zero;
  msx_fwrite_t fwr;
  logic unhandled;
  logic [13:0] w;

  assign w = ISSUE.word;

  // opcode matching
  // the four prefixes never overlap, so at most one match is high per word;
  // each comparison is a plain equality on a slice of the word
  wire is_store = ISSUE.valid && (w[13:STORE_POS] == STORE_PREFIX);
  wire is_swap = ISSUE.valid && (w[13:SWAP_POS] == SWAP_PREFIX);
  wire is_xor = ISSUE.valid && (w[13:XOR_POS] == XOR_PREFIX);
  wire [2:0] dir_sel = w[DIR_SEL_W-1:0];
  // selectors outside 5..7 are not a direction load and fall to unhandled
  wire is_dir = ISSUE.valid && (w[13:DIR_POS] == DIR_PREFIX)
    && (dir_sel >= DIR_SEL_MIN) && (dir_sel <= DIR_SEL_MAX);
  wire dest_file = w[DEST_BIT];
  wire [6:0] faddr = w[FADDR_W-1:0];
  wire [7:0] literal = w[DATA_W-1:0];

  msx_op_t op;
  assign op = is_store ? MSX_OP_STORE : is_swap ? MSX_OP_SWAP :
              is_xor ? MSX_OP_XOR : is_dir ? MSX_OP_DIR : MSX_OP_NONE;

  // datapath results
  // the swap source comes straight off the file read port in the same cycle,
  // which keeps the instruction at one cycle at the cost of a longer path
  wire [7:0] swapped = nib_swap(FILE_RDATA);
  wire [7:0] xored = acc ^ literal;
  assign FILE_RADDR = faddr;

  // next-state selection
  // every path starts from acc and zero held and no file write, so store, swap and direction load
  // cannot disturb the zero flag by accident
  logic [7:0] next_acc;
  logic next_zero;
  msx_fwrite_t next_fwr;
  always_comb begin
    next_acc = acc;
    next_zero = zero;
    next_fwr = '{en: 1'b0, addr: faddr, data: 8'h00};
    case (op)
      MSX_OP_STORE: begin
        next_fwr = '{en: 1'b1, addr: faddr, data: acc};
      end
      MSX_OP_SWAP: begin
        if (dest_file) begin
          next_fwr = '{en: 1'b1, addr: faddr, data: swapped};
        end else begin
          next_acc = swapped;
        end
      end
      MSX_OP_XOR: begin
        next_acc = xored;
        next_zero = (xored == 8'h00);
      end
      default: begin
      end
    endcase
  end

  // core state registers; flags untouched by store, swap and direction load
  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      acc <= ACC_RESET;
      zero <= ZERO_RESET;
      fwr <= '0;
      unhandled <= 1'b0;
    end else begin
      acc <= next_acc;
      zero <= next_zero;
      fwr <= next_fwr;
      unhandled <= ISSUE.valid && (op == MSX_OP_NONE);
    end
  end

  // kept for older code; software would rather write these through file addresses
  msx_dir_regs u_dir (
    .REF_CLK(REF_CLK),
    .RST_B(RST_B),
    .wr_en(is_dir),
    .wr_idx(2'(dir_sel - DIR_SEL_MIN)),
    .wr_data(acc),
    .dir_flat(DIR_REGS)
  );

  assign ACC = acc;
  assign ZERO = zero;
  assign FILE_WR = fwr;
  assign UNHANDLED = unhandled;

  // checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);

  sequence swap_to_acc_s;
    is_swap && !dest_file;
  endsequence
  sequence swap_to_file_s;
    is_swap && dest_file;
  endsequence

  sequence dir_bad_sel_s;
    ISSUE.valid && (w[13:DIR_POS] == DIR_PREFIX) && (dir_sel < DIR_SEL_MIN);
  endsequence
  sequence xor_to_zero_s;
    is_xor && (acc == literal);
  endsequence

  // swap into the accumulator, high nibble from the low source nibble
  swap_acc_value_a: assert property (swap_to_acc_s |=>
    ACC[7:4] == $past(FILE_RDATA[3:0]) && ACC[3:0] == $past(FILE_RDATA[7:4]))
    else $error("swap to accumulator wrong value");

  // swap into the accumulator must not also write the file
  swap_low_nibble_a: assert property (swap_to_acc_s |=>
    ACC[3:0] == $past(FILE_RDATA[7:4]) && !FILE_WR.en)
    else $error("swap to accumulator wrote the file");
  swap_file_dest_a: assert property (swap_to_file_s |=> FILE_WR.en && FILE_WR.addr == $past(faddr)
    && FILE_WR.data == {$past(FILE_RDATA[3:0]), $past(FILE_RDATA[7:4])} && $stable(ACC))
    else $error("swap to file wrong");
  swap_flags_a: assert property (is_swap |=> $stable(ZERO))
    else $error("swap changed zero flag");
  xor_result_a: assert property (is_xor |=> ACC == ($past(ACC) ^ $past(w[7:0]))
    && ZERO == (ACC == 8'h00) && !FILE_WR.en)
    else $error("literal xor wrong");
  dir_load_a: assert property (is_dir && dir_sel == 3'h6 |=> DIR_REGS[15:8] == $past(ACC))
    else $error("direction load wrong register");
  dir_flags_a: assert property (is_dir |=> $stable(ZERO) && $stable(ACC) && !FILE_WR.en)
    else $error("direction load side effect");
  store_write_a: assert property (is_store |=> FILE_WR.en && FILE_WR.data == $past(ACC)
    && FILE_WR.addr == $past(w[6:0]) && $stable(ZERO))
    else $error("store write wrong");
  idle_no_write_a: assert property (!ISSUE.valid |=> !FILE_WR.en && $stable(ACC) && !UNHANDLED)
    else $error("write without instruction");

  // the lowest and highest selectors land in their own slots only
  dir_load_low_a: assert property (is_dir && dir_sel == 3'h5 |=>
    DIR_REGS[7:0] == $past(ACC) && $stable(DIR_REGS[23:8]))
    else $error("direction load slot five wrong");

  dir_load_high_a: assert property (is_dir && dir_sel == 3'h7 |=>
    DIR_REGS[23:16] == $past(ACC) && $stable(DIR_REGS[15:0]))
    else $error("direction load slot seven wrong");

  // selectors below five are refused and leave the registers alone
  dir_bad_sel_a: assert property (dir_bad_sel_s |=> UNHANDLED && $stable(DIR_REGS))
    else $error("refused selector touched direction registers");

  // only a direction load may move the direction registers
  dir_source_a: assert property ($changed(DIR_REGS) |-> $past(is_dir))
    else $error("direction registers changed without a load");

  // only the literal xor may move the zero flag
  zero_source_a: assert property ($changed(ZERO) |-> $past(is_xor))
    else $error("zero flag changed outside literal xor");

  // a literal equal to the accumulator must clear it and raise zero
  xor_zero_set_a: assert property (xor_to_zero_s |=> ZERO && ACC == 8'h00)
    else $error("xor to zero missed the flag");

  // only xor and swap to the accumulator may move it
  acc_source_a: assert property ($changed(ACC) |-> $past(is_xor || (is_swap && !dest_file)))
    else $error("accumulator changed by wrong instruction");

  // store leaves the accumulator and is never flagged as unknown
  store_acc_keep_a: assert property (is_store |=> $stable(ACC) && !UNHANDLED)
    else $error("store disturbed the accumulator");

  // a file write strobe needs a store or a swap back to the file
  file_write_cause_a: assert property (FILE_WR.en |->
    $past(is_store || (is_swap && dest_file)))
    else $error("file write without cause");
endmodule

// ### include/msx_pkg.sv
// shared constants and carrier types for the four-instruction decode/execute block
package msx_pkg;
  // instruction word layout
  localparam int INSTR_W = 14;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int DIR_SEL_W = 3;
  localparam int DEST_BIT = 7;
  // opcode prefixes and their positions
  localparam logic [6:0] STORE_PREFIX = 7'h01;     // 00 0000 1 at bits 13..7
  localparam int STORE_POS = 7;
  localparam logic [5:0] SWAP_PREFIX = 6'h0e;      // 00 1110 at bits 13..8
  localparam int SWAP_POS = 8;
  localparam logic [5:0] XOR_PREFIX = 6'h3a;       // 11 1010 at bits 13..8
  localparam int XOR_POS = 8;
  localparam logic [10:0] DIR_PREFIX = 11'h00c;    // 00 0000 0110 0 at bits 13..3
  localparam int DIR_POS = 3;
  // direction register selector range
  localparam logic [2:0] DIR_SEL_MIN = 3'h5;
  localparam logic [2:0] DIR_SEL_MAX = 3'h7;
  localparam int DIR_COUNT = 3;
  // reset values
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] DIR_RESET = 8'hff;
  localparam logic ZERO_RESET = 1'b0;

  // decoded operation
  typedef enum {
    MSX_OP_NONE,
    MSX_OP_STORE,
    MSX_OP_SWAP,
    MSX_OP_XOR,
    MSX_OP_DIR
  } msx_op_t;

  // file register write request
  typedef struct packed {
    logic en;
    logic [6:0] addr;
    logic [7:0] data;
  } msx_fwrite_t;

  // instruction issue from the fetch path
  typedef struct packed {
    logic valid;
    logic [13:0] word;
  } msx_issue_t;
endpackage

// ### rtl/msx_dir_regs.sv
// small memory holding the three port direction registers
`timescale 1ns/1ps
module msx_dir_regs (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST_B,
  // write port
  input wire logic wr_en,
  input wire logic [1:0] wr_idx,
  input wire logic [7:0] wr_data,
  // flat view of all registers, each from a flip-flop
  output logic [23:0] dir_flat
);
  import msx_pkg::*;

  logic [7:0] mem [DIR_COUNT];

  // direction registers reset to all inputs so pins float safely at start
  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      for (int i = 0; i < DIR_COUNT; i++) begin
        mem[i] <= DIR_RESET;
      end
    end else if (wr_en && (wr_idx < 2'(DIR_COUNT))) begin
      mem[wr_idx] <= wr_data;
    end
  end

  assign dir_flat = {mem[2], mem[1], mem[0]};
endmodule

// ### dv/tb_top.sv
// self-checking bench for the store, swap, xor and direction-load block
`timescale 1ns/1ps
module tb_top;
  import msx_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  msx_issue_t issue = '0;
  logic [7:0] file_rdata = 8'h00;
  logic [6:0] file_raddr;
  msx_fwrite_t file_wr;
  logic [7:0] acc;
  logic zero;
  logic [23:0] dir_regs;
  logic unhandled;
  logic [7:0] acc_exp = 8'h00;
  logic [23:0] dir_exp = 24'hffffff;
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;

  msx_exec msx_exec_i (.REF_CLK(ref_clk), .RST_B(rst_b), .ISSUE(issue),
    .FILE_RDATA(file_rdata), .FILE_RADDR(file_raddr), .FILE_WR(file_wr),
    .ACC(acc), .ZERO(zero), .DIR_REGS(dir_regs), .UNHANDLED(unhandled));

  // 125 MHz clock
  always #4 ref_clk = ~ref_clk;

  // hang guard: the whole run needs well under a hundred cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one instruction for one cycle; on return the results of the taking edge are settled
  task automatic run(input logic [13:0] w, input logic [7:0] rd);
    @(negedge ref_clk);
    issue = {1'b1, w};
    file_rdata = rd;
    #1 chk("raddr", file_raddr, w[6:0]);
    @(negedge ref_clk);
    issue.valid = 1'b0;
  endtask

  // literal xor with its own expectation
  task automatic xor_k(input logic [7:0] k);
    acc_exp = acc_exp ^ k;
    run(14'h3a00 | k, 8'h00);
    chk("acc", acc, acc_exp);
    chk("zero", zero, acc_exp == 8'h00);
  endtask

  task automatic t_reset();
    chk("acc", acc, ACC_RESET);
    chk("zero", zero, ZERO_RESET);
    chk("dir", dir_regs, {3{DIR_RESET}});
    chk("wr", file_wr.en, 1'b0);
    chk("unh", unhandled, 1'b0);
  endtask

  task automatic t_store();
    xor_k(8'hff);
    run(14'h00ff, 8'h00);
    chk("wr", file_wr, {1'b1, 7'h7f, 8'hff});
    chk("zero", zero, 1'b0);
    run(14'h0080, 8'h00);
    chk("wr", file_wr, {1'b1, 7'h00, 8'hff});
    @(negedge ref_clk);
    chk("wr", file_wr.en, 1'b0);
  endtask

  task automatic t_swap();
    xor_k(8'hff);
    run(14'h0e12, 8'ha5);
    chk("acc", acc, 8'h5a);
    chk("wr", file_wr.en, 1'b0);
    chk("zero", zero, 1'b1);
    run(14'h0eb3, 8'h3c);
    chk("wr", file_wr, {1'b1, 7'h33, 8'hc3});
    chk("acc", acc, 8'h5a);
    acc_exp = 8'h5a;
  endtask

  task automatic t_dir();
    for (int s = 5; s <= 7; s++) begin
      xor_k(8'h11 * s[7:0]);
      run(14'h0060 | s[13:0], 8'h00);
      dir_exp[(s - 5) * 8 +: 8] = acc_exp;
      chk("dir", dir_regs, dir_exp);
      chk("zero", zero, acc_exp == 8'h00);
    end
    run(14'h0064, 8'h00);
    chk("unh", unhandled, 1'b1);
    chk("dir", dir_regs, dir_exp);
    @(negedge ref_clk);
    chk("unh", unhandled, 1'b0);
  endtask

  // reset for eight cycles, then the scenarios in turn
  initial begin
    repeat (8) @(negedge ref_clk);
    t_reset();
    rst_b = 1'b1;
    t_store();
    t_swap();
    t_dir();
    give_verdict();
  end
endmodule
